// File: rtl/ipr_pkg.sv
// Purpose: constants and types for the input reference prescaler
// Assumes: 10 MHz system clock, APB register access
// Notes: register indices are word indices; byte address = index * 4
package ipr_pkg;
    localparam int NUM_IN = 14;
    localparam int CLK_PERIOD_NS = 100;
    localparam int AMI_LOS_TIME_US = 1000;
    localparam int AMI_LOS_CYC = AMI_LOS_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int FREQ_WIN_TIME_US = 1000;
    localparam int FREQ_WIN_CYC = FREQ_WIN_TIME_US * 1000 / CLK_PERIOD_NS;
    // ---------------------------------------------------------------
    // register indices
    // ---------------------------------------------------------------
    localparam logic [7:0] IDX_TCTL = 8'h03;
    localparam logic [7:0] IDX_FCFG0 = 8'h20;
    localparam logic [7:0] IDX_FCFG13 = 8'h2D;
    localparam logic [7:0] IDX_MODE = 8'h34;
    localparam logic [7:0] IDX_DIFF = 8'h35;
    localparam logic [7:0] IDX_MON0 = 8'h38;
    localparam logic [7:0] IDX_MON3 = 8'h3B;
    localparam logic [7:0] IDX_NLO = 8'h46;
    localparam logic [7:0] IDX_NHI = 8'h47;
    localparam logic [7:0] IDX_PRIO0 = 8'h50;
    localparam logic [7:0] IDX_PRIO13 = 8'h5D;
    localparam logic [7:0] IDX_UNAV = 8'h60;
    localparam logic [7:0] IDX_AMI = 8'h61;
    localparam logic [7:0] IDX_OOB = 8'h62;
    // ---------------------------------------------------------------
    // fields, codes and reset values
    // ---------------------------------------------------------------
    localparam int TCTL_EDGE_POL = 2;
    localparam int MODE_SONET = 2;
    localparam int FCFG_PRESCALE_VALUE_HIGH = 7;
    localparam int FCFG_L8K = 6;
    localparam int ACT_UNIT_SH = 4;
    localparam int DIFF_CH_A = 4;
    localparam int DIFF_CH_B = 5;
    localparam logic [13:0] PRESCALE_VALUE_HIGH_MIN = 14'h0001;
    localparam logic [13:0] PRESCALE_VALUE_HIGH_MAX = 14'h30D3;
    localparam logic [3:0] FC_8K = 4'h0, FC_T1E1 = 4'h1, FC_6M48 = 4'h2, FC_19M44 = 4'h3;
    localparam logic [3:0] FC_25M92 = 4'h4, FC_38M88 = 4'h5, FC_51M84 = 4'h6, FC_77M76 = 4'h7;
    localparam logic [3:0] FC_155M52 = 4'h8, FC_2K = 4'h9, FC_4K = 4'hA, FC_COMP = 4'hB;
    localparam logic [13:0][3:0] DEF_CODE = 56'h1111_3333_3300_BB;
    localparam logic [3:0] SLAVE_PRIO = 4'h1;
    localparam logic [7:0] DIFF_RST = 8'h02;
    localparam logic [3:0][7:0] MON_RST = 32'h8040_2010;
    localparam logic [3:0] FREQ_LO = 4'h7;
    localparam logic [3:0] FREQ_HI = 4'h9;
    localparam logic [3:0] AMI_MARKS = 4'h8;
    localparam logic [2:0] AMI_DEP_LIMIT = 3'h4;
    localparam logic [1:0] INIT_LOAD = 2'h2;
    // ---------------------------------------------------------------
    // types
    // ---------------------------------------------------------------
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } ipr_apb_req_t;
    typedef struct packed {
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } ipr_apb_rsp_t;
    typedef struct packed {
        logic [13:2] ref_m, ref_s, lvl;
        logic [1:0] pos_m, pos_s, neg_m, neg_s, pos_p, neg_p, pol;
        logic [1:0] strap_m, strap_s;
        logic [1:0] init_cnt;
        logic [7:0] tctl, mode, diff, nlo, nhi;
        logic [13:0][7:0] fcfg;
        logic [3:0][7:0] mon;
        logic [13:0][3:0] prio;
        logic [13:0][14:0] div;
        logic [13:0] cmp;
        logic [13:0][15:0] idle;
        logic [13:0] act_lost;
        logic [15:0] win;
        logic [13:0][3:0] fcnt;
        logic [13:0] oob;
        logic [1:0][3:0] marks;
        logic [1:0][15:0] los_cnt;
        logic [1:0] los, ami_bad, dep_sticky;
        logic [1:0][2:0] deps;
        logic [13:0] unavail;
        ipr_apb_rsp_t apb;
    } ipr_state_t;
endpackage : ipr_pkg

// File: rtl/ipr_input_prescaler.sv
// Purpose: input reference front end: prescaling, AMI decode, monitors
// Assumes: reference pins are slow enough to be sampled at the system clock
// Notes: one packed state, one comb process, one register process
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
module ipr_input_prescaler
    import ipr_pkg::*;
#(
    parameter int LOS_CYC = AMI_LOS_CYC,
    parameter int WIN_CYC = FREQ_WIN_CYC
) (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire ipr_apb_req_t apb_i,
    output ipr_apb_rsp_t apb_o,
    input wire logic [13:2] ref_clk_i,
    input wire logic [1:0] ami_pos_i,
    input wire logic [1:0] ami_neg_i,
    input wire logic network_standard_pin_i,
    input wire logic master_slave_pin_i,
    output logic [13:0] cmp_edge_o,
    output logic [13:0] unavail_o,
    output logic [1:0] ami_los_o,
    output logic [1:0] diff_pecl_sel_o,
    output logic network_standard_sel_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!nrst_i);
    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    // divide-by-(factor) minus one needed to reach 8 kHz from a spot code
    function automatic logic [14:0] auto_lim(input logic [3:0] code, input logic sonet);
        case (code)
            FC_T1E1: auto_lim = sonet ? 15'd192 : 15'd255;
            FC_6M48: auto_lim = 15'd809;
            FC_19M44: auto_lim = 15'd2429;
            FC_25M92: auto_lim = 15'd3239;
            FC_38M88: auto_lim = 15'd4859;
            FC_51M84: auto_lim = 15'd6479;
            FC_77M76: auto_lim = 15'd9719;
            FC_155M52: auto_lim = 15'd19439;
            default: auto_lim = 15'd0;
        endcase
    endfunction : auto_lim

    ipr_state_t q, d;

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    logic [13:0] n_raw, n_eff;
    logic [7:0] idx;
    logic acc, hit, wr;
    logic [7:0] rd;
    logic win_end;
    logic [13:0] edg;
    logic [14:0] lim;
    logic [3:0] code;
    logic cfg_bad, divided;
    logic [1:0] mark, viol, dep;
    logic pr, nr;

    always_comb begin
        d = q;
        n_raw = {q.nhi[5:0], q.nlo};
        // out-of-range N is clamped so the divider never stalls
        n_eff = (n_raw < PRESCALE_VALUE_HIGH_MIN) ? PRESCALE_VALUE_HIGH_MIN : (n_raw > PRESCALE_VALUE_HIGH_MAX) ? PRESCALE_VALUE_HIGH_MAX : n_raw;
        idx = apb_i.paddr[9:2];
        acc = apb_i.psel && apb_i.penable && !q.apb.pready;
        wr = 1'b0;
        hit = 1'b1;
        rd = 8'h00;
        win_end = (q.win == 16'(WIN_CYC - 1));
        edg = '0;
        lim = '0;
        code = '0;
        cfg_bad = 1'b0;
        divided = 1'b0;
        mark = '0;
        viol = '0;
        dep = '0;
        pr = 1'b0;
        nr = 1'b0;
        // pin synchronisers
        d.ref_m = ref_clk_i;
        d.ref_s = q.ref_m;
        d.pos_m = ami_pos_i;
        d.pos_s = q.pos_m;
        d.neg_m = ami_neg_i;
        d.neg_s = q.neg_m;
        d.strap_m = {master_slave_pin_i, network_standard_pin_i};
        d.strap_s = q.strap_m;
        d.win = win_end ? 16'h0000 : q.win + 16'h0001;

        // AMI composite clock decoders on inputs one and two
        for (int a = 0; a < 2; a++) begin
            pr = q.pos_s[a] && !q.pos_p[a];
            nr = q.neg_s[a] && !q.neg_p[a];
            d.pos_p[a] = q.pos_s[a];
            d.neg_p[a] = q.neg_s[a];
            mark[a] = pr || nr;
            // a mark repeating the last polarity is a coding violation
            viol[a] = mark[a] && (pr == q.pol[a]);
            if (mark[a]) begin
                d.pol[a] = pr;
                if (viol[a]) begin
                    dep[a] = (q.marks[a] != AMI_MARKS);
                    d.marks[a] = 4'h1;
                end else if (q.marks[a] >= AMI_MARKS) begin
                    dep[a] = 1'b1;
                    d.marks[a] = 4'h1;
                end else begin
                    d.marks[a] = q.marks[a] + 4'h1;
                end
            end
            if (mark[a]) begin
                d.los_cnt[a] = 16'h0000;
                d.los[a] = 1'b0;
            end else if (q.los_cnt[a] == 16'(LOS_CYC - 1)) begin
                d.los[a] = 1'b1;
            end else begin
                d.los_cnt[a] = q.los_cnt[a] + 16'h0001;
            end
            if (dep[a] && q.deps[a] != 3'h7) begin
                d.deps[a] = q.deps[a] + 3'h1;
            end
            // frequent departures within a window disqualify the input
            if (win_end) begin
                d.ami_bad[a] = (q.deps[a] >= AMI_DEP_LIMIT) || (dep[a] && q.deps[a] >= AMI_DEP_LIMIT - 3'h1);
                d.deps[a] = 3'h0;
            end
        end

        // per-input edge selection, divider and monitors, each input on its own
        for (int k = 0; k < NUM_IN; k++) begin
            code = q.fcfg[k][3:0];
            if (k < 2) begin
                // locking to 8k on a composite clock uses the frame violations
                edg[k] = q.fcfg[k][FCFG_L8K] ? viol[k] : mark[k];
            end else begin
                d.lvl[k] = q.ref_s[k];
                edg[k] = q.tctl[TCTL_EDGE_POL] ? (!q.ref_s[k] && q.lvl[k])
                                               : (q.ref_s[k] && !q.lvl[k]);
            end
            if (q.fcfg[k][FCFG_PRESCALE_VALUE_HIGH]) begin
                lim = {1'b0, n_eff};
            end else if (q.fcfg[k][FCFG_L8K]) begin
                lim = auto_lim(code, q.mode[MODE_SONET]);
            end else if (code == FC_155M52) begin
                lim = 15'd1;
            end else begin
                lim = 15'd0;
            end
            d.cmp[k] = 1'b0;
            if (edg[k]) begin
                if (q.div[k] >= lim) begin
                    d.div[k] = 15'd0;
                    d.cmp[k] = 1'b1;
                end else begin
                    d.div[k] = q.div[k] + 15'd1;
                end
            end
            // activity: idle time against the selected configuration
            if (k < 2 ? mark[k] : edg[k]) begin
                d.idle[k] = 16'h0000;
                d.act_lost[k] = 1'b0;
            end else begin
                if (q.idle[k] != 16'hFFFF) begin
                    d.idle[k] = q.idle[k] + 16'h0001;
                end
                d.act_lost[k] = q.idle[k] >= {4'h0, q.mon[q.fcfg[k][5:4]], 4'h0};
            end
            // frequency check on the divided 8 kHz stream
            divided = (q.fcfg[k][FCFG_PRESCALE_VALUE_HIGH] || q.fcfg[k][FCFG_L8K]) && code != FC_2K && code != FC_4K;
            if (q.cmp[k] && q.fcnt[k] != 4'hF) begin
                d.fcnt[k] = q.fcnt[k] + 4'h1;
            end
            if (win_end) begin
                d.fcnt[k] = 4'h0;
                if (!divided) begin
                    d.oob[k] = 1'b0;
                end else if (!q.act_lost[k] && !(k < 2 && q.ami_bad[k])) begin
                    d.oob[k] = q.fcnt[k] < FREQ_LO || q.fcnt[k] > FREQ_HI;
                end
            end
            cfg_bad = (code > FC_COMP) || (code == FC_155M52 && k != DIFF_CH_A && k != DIFF_CH_B);
            d.unavail[k] = q.act_lost[k] || q.oob[k] || cfg_bad
                           || (k < 2 && (q.los[k] || q.ami_bad[k]));
        end
        d.dep_sticky = q.dep_sticky | dep;

        // APB register access, one wait state
        d.apb.pready = acc;
        d.apb.pslverr = 1'b0;
        d.apb.prdata = 32'h0000_0000;
        if (apb_i.paddr[1:0] != 2'b00 || apb_i.paddr[11:10] != 2'b00) begin
            hit = 1'b0;
        end else if (idx >= IDX_FCFG0 && idx <= IDX_FCFG13) begin
            rd = q.fcfg[idx - IDX_FCFG0];
        end else if (idx >= IDX_MON0 && idx <= IDX_MON3) begin
            rd = q.mon[idx - IDX_MON0];
        end else if (idx >= IDX_PRIO0 && idx <= IDX_PRIO13) begin
            rd = {4'h0, q.prio[idx - IDX_PRIO0]};
        end else begin
            case (idx)
                IDX_TCTL: rd = q.tctl;
                IDX_MODE: rd = q.mode;
                IDX_DIFF: rd = q.diff;
                IDX_NLO: rd = q.nlo;
                IDX_NHI: rd = q.nhi;
                IDX_UNAV: rd = q.unavail[7:0];
                IDX_AMI: rd = {2'b00, q.dep_sticky, q.ami_bad, q.los};
                IDX_OOB: rd = q.oob[7:0];
                default: hit = 1'b0;
            endcase
        end
        if (acc) begin
            d.apb.pslverr = !hit;
            d.apb.prdata = {24'h000000, rd};
            if (idx == IDX_UNAV || idx == IDX_OOB) begin
                d.apb.prdata = {18'h00000, (idx == IDX_UNAV) ? q.unavail : q.oob};
            end
            wr = hit && apb_i.pwrite;
        end
        if (wr) begin
            if (idx >= IDX_FCFG0 && idx <= IDX_FCFG13) begin
                d.fcfg[idx - IDX_FCFG0] = apb_i.pwdata[7:0];
            end else if (idx >= IDX_MON0 && idx <= IDX_MON3) begin
                d.mon[idx - IDX_MON0] = apb_i.pwdata[7:0];
            end else if (idx >= IDX_PRIO0 && idx <= IDX_PRIO13) begin
                d.prio[idx - IDX_PRIO0] = apb_i.pwdata[3:0];
            end else begin
                case (idx)
                    IDX_TCTL: d.tctl = apb_i.pwdata[7:0];
                    IDX_MODE: d.mode = apb_i.pwdata[7:0];
                    IDX_DIFF: d.diff = apb_i.pwdata[7:0];
                    IDX_NLO: d.nlo = apb_i.pwdata[7:0];
                    IDX_NHI: d.nhi = apb_i.pwdata[7:0];
                    // new departures still set the bit in the clearing cycle
                    IDX_AMI: d.dep_sticky = (q.dep_sticky & ~apb_i.pwdata[5:4]) | dep;
                    default: d.tctl = q.tctl;
                endcase
            end
        end

        // straps are taken once the synchronisers hold settled levels
        if (q.init_cnt != 2'h3) begin
            d.init_cnt = q.init_cnt + 2'h1;
        end
        if (q.init_cnt == INIT_LOAD) begin
            d.mode[MODE_SONET] = q.strap_s[0];
            if (!q.strap_s[1]) begin
                d.prio[10] = SLAVE_PRIO;
                d.fcfg[10] = {4'h0, FC_6M48};
            end
        end
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            q <= '0;
            q.diff <= DIFF_RST;
            q.mon <= MON_RST;
            for (int k = 0; k < NUM_IN; k++) begin
                q.fcfg[k] <= {4'h0, DEF_CODE[k]};
                q.prio[k] <= 4'(k + 2);
            end
        end else begin
            q <= d;
        end
    end

    assign apb_o = q.apb;
    assign cmp_edge_o = q.cmp;
    assign unavail_o = q.unavail;
    assign ami_los_o = q.los;
    assign diff_pecl_sel_o = q.diff[1:0];
    assign network_standard_sel_o = q.mode[MODE_SONET];

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    // an in-range value must reach the divider untouched, only outliers are clamped
    property p_n_range;
        n_eff >= PRESCALE_VALUE_HIGH_MIN && n_eff <= PRESCALE_VALUE_HIGH_MAX && (n_raw < PRESCALE_VALUE_HIGH_MIN || n_raw > PRESCALE_VALUE_HIGH_MAX || n_eff == n_raw);
    endproperty
    a_n_range: assert property (p_n_range) else $error("prescale factor out of range");

    property p_strap_std;
        q.init_cnt == INIT_LOAD |=> q.mode[MODE_SONET] == $past(q.strap_s[0]);
    endproperty
    a_strap_std: assert property (p_strap_std) else $error("standard bit not loaded from pin");

    property p_strap_prio;
        q.init_cnt == INIT_LOAD |=> q.prio[10] == ($past(q.strap_s[1]) ? 4'hC : SLAVE_PRIO);
    endproperty
    a_strap_prio: assert property (p_strap_prio) else $error("input eleven priority wrong");

    sequence s_direct6;
        !q.fcfg[6][FCFG_PRESCALE_VALUE_HIGH] && !q.fcfg[6][FCFG_L8K] && q.fcfg[6][3:0] != FC_155M52 && edg[6];
    endsequence
    property p_direct;
        s_direct6 |=> q.cmp[6];
    endproperty
    a_direct: assert property (p_direct) else $error("native edge not passed");

    sequence s_half4;
        q.fcfg[4][7:6] == 2'b00 && q.fcfg[4][3:0] == FC_155M52 && edg[4] && q.div[4] == 15'd0;
    endsequence
    property p_half;
        s_half4 |=> !q.cmp[4];
    endproperty
    a_half: assert property (p_half) else $error("155 MHz input not halved");

    // both mode bits set: the shared factor, not the automatic one, must end the count
    sequence s_both5;
        q.fcfg[5][FCFG_PRESCALE_VALUE_HIGH] && q.fcfg[5][FCFG_L8K] && edg[5] && q.div[5] >= {1'b0, n_eff};
    endsequence
    property p_prescale_value_high_prec;
        s_both5 |=> q.cmp[5] ##1 q.div[5] == 15'd0;
    endproperty
    a_prescale_value_high_prec: assert property (p_prescale_value_high_prec) else $error("prescaler did not take precedence");

    property p_los;
        !mark[0] && q.los_cnt[0] == 16'(LOS_CYC - 1) |=> q.los[0] ##1 q.unavail[0];
    endproperty
    a_los: assert property (p_los) else $error("AMI loss of signal not declared");

    property p_unavail;
        q.act_lost[7] |=> q.unavail[7];
    endproperty
    a_unavail: assert property (p_unavail) else $error("lost input still available");

    property p_single_155;
        q.fcfg[2][3:0] == FC_155M52 |=> q.unavail[2];
    endproperty
    a_single_155: assert property (p_single_155) else $error("155 MHz accepted on single-ended input");

    property p_freq_gate;
        q.act_lost[7] && win_end |=> $stable(q.oob[7]);
    endproperty
    a_freq_gate: assert property (p_freq_gate) else $error("frequency checked on idle input");

    property p_apb;
        acc |=> q.apb.pready ##1 !q.apb.pready;
    endproperty
    a_apb: assert property (p_apb) else $error("APB answer not one cycle");
endmodule : ipr_input_prescaler

// File: tb/ipr_ref_src.sv
// Purpose: model of the external reference clock sources
// Assumes: changes follow the system clock edge
// Notes: clocks stand low between bursts, as a stopped source does
`timescale 1ns/1ps
module ipr_ref_src (
    input wire logic sys_clk_i,
    output logic [13:2] ref_o,
    output logic [1:0] pos_o,
    output logic [1:0] neg_o
);
    initial begin
        ref_o = '0;
        pos_o = '0;
        neg_o = '0;
    end
    // ---------------------------------------------------------------
    // stimulus tasks
    // ---------------------------------------------------------------
    // all masked pins run at one rate, as shared prescaling needs
    task automatic burst(input logic [13:2] mask, input int n, input int half);
        for (int i = 0; i < n; i++) begin
            repeat (half) @(posedge sys_clk_i);
            ref_o <= ref_o | mask;
            repeat (half) @(posedge sys_clk_i);
            ref_o <= ref_o & ~mask;
        end
    endtask : burst
    task automatic level(input int ch, input logic v);
        @(posedge sys_clk_i);
        ref_o[ch] <= v;
    endtask : level
    task automatic mark(input int ch);
        @(posedge sys_clk_i);
        pos_o[ch] <= 1'b1;
        repeat (4) @(posedge sys_clk_i);
        pos_o[ch] <= 1'b0;
    endtask : mark
endmodule : ipr_ref_src

// File: tb/testbench.sv
// Purpose: self-checking bench for the input reference prescaler
// Assumes: straps tied to SONET master
// Notes: divider counts use multiples of the ratio, so phase does not matter
`timescale 1ns/1ps
module testbench;
    import ipr_pkg::*;
    logic sys_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    ipr_apb_req_t apb_i = '0;
    ipr_apb_rsp_t apb_o;
    logic [13:2] ref_clk;
    logic [1:0] ami_pos;
    logic [1:0] ami_neg;
    logic [13:0] cmp_edge;
    logic [13:0] unavail;
    logic [1:0] ami_los;
    logic [1:0] diff_sel;
    logic net_sel;
    int errors = 0;
    int num_checks = 0;
    int cnt [14];
    int base [6];
    logic [7:0] cfg [6] = '{8'h80, 8'h80, 8'h08, 8'hC3, 8'h03, 8'h41};
    int expn [6] = '{193, 193, 386, 193, 772, 4};
    logic [31:0] rd;
    logic err;
    always #50 sys_clk_i = ~sys_clk_i;
    ipr_input_prescaler #(.LOS_CYC(200), .WIN_CYC(400)) i_dut (
        .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .apb_i(apb_i), .apb_o(apb_o),
        .ref_clk_i(ref_clk), .ami_pos_i(ami_pos), .ami_neg_i(ami_neg),
        .network_standard_pin_i(1'b1), .master_slave_pin_i(1'b1),
        .cmp_edge_o(cmp_edge), .unavail_o(unavail), .ami_los_o(ami_los),
        .diff_pecl_sel_o(diff_sel), .network_standard_sel_o(net_sel)
    );
    ipr_ref_src i_src (.sys_clk_i(sys_clk_i), .ref_o(ref_clk), .pos_o(ami_pos), .neg_o(ami_neg));
    always @(posedge sys_clk_i) begin
        for (int i = 0; i < 14; i++) begin
            if (cmp_edge[i] === 1'b1) cnt[i]++;
        end
    end
    // ---------------------------------------------------------------
    // tasks
    // ---------------------------------------------------------------
    task automatic summarize;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk
    // request held until pready is sampled high; the slave sets the pace
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        @(posedge sys_clk_i);
        apb_i.psel <= 1'b1;
        apb_i.penable <= 1'b0;
        apb_i.pwrite <= wr;
        apb_i.paddr <= {2'b00, idx, 2'b00};
        apb_i.pwdata <= wd;
        @(posedge sys_clk_i);
        apb_i.penable <= 1'b1;
        // no own limit: a hung slave is caught by the watchdog
        do begin
            @(posedge sys_clk_i);
        end while (apb_o.pready !== 1'b1);
        rd = apb_o.prdata;
        err = apb_o.pslverr;
        apb_i.psel <= 1'b0;
        apb_i.penable <= 1'b0;
    endtask : apb
    task automatic rchk(input logic [7:0] idx, input logic [31:0] exp, input string msg);
        apb(1'b0, idx, 32'h0);
        chk(rd, exp, msg);
    endtask : rchk
    // ---------------------------------------------------------------
    // tests
    // ---------------------------------------------------------------
    initial begin
        repeat (20) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        repeat (6) @(posedge sys_clk_i);
        chk(net_sel, 1, "strap standard");
        rchk(IDX_MODE, 32'h04, "mode reset");
        for (int c = 0; c < NUM_IN; c++) begin
            rchk(IDX_PRIO0 + 8'(c), 32'(c + 2), "priority");
            rchk(IDX_FCFG0 + 8'(c), {28'h0, DEF_CODE[c]}, "frequency code");
        end
        apb(1'b1, IDX_MODE, 32'h00);
        chk(net_sel, 0, "sdh select");
        rchk(IDX_DIFF, 32'h02, "diff reset");
        chk(diff_sel, 2'b10, "diff pins");
        apb(1'b1, IDX_DIFF, 32'h01);
        chk(diff_sel, 2'b01, "diff write");
        rchk(8'h10, 32'h0, "unmapped data");
        chk(err, 1, "unmapped error");
        $display("test registers done");
        repeat (300) @(posedge sys_clk_i);
        chk(ami_los, 2'b11, "ami silent");
        chk(unavail[13], 1, "idle input");
        i_src.mark(0);
        repeat (10) @(posedge sys_clk_i);
        chk(ami_los, 2'b10, "ami mark");
        i_src.mark(0);
        repeat (10) @(posedge sys_clk_i);
        apb(1'b0, IDX_AMI, 32'h0);
        chk(rd[4], 1, "repeated polarity departure");
        apb(1'b1, IDX_AMI, 32'h10);
        apb(1'b0, IDX_AMI, 32'h0);
        chk(rd[4], 0, "departure cleared");
        $display("test activity done");
        // lock-to-8k on 1.544 MHz needs the sonet set back
        apb(1'b1, IDX_MODE, 32'h04);
        apb(1'b1, IDX_NLO, 32'h03);
        apb(1'b1, IDX_NHI, 32'h00);
        rchk(IDX_NLO, 32'h03, "n low");
        rchk(IDX_NHI, 32'h00, "n high");
        for (int c = 0; c < 6; c++) begin
            apb(1'b1, IDX_FCFG0 + 8'(c + 2), {24'h0, cfg[c]});
            base[c] = cnt[c + 2];
        end
        i_src.burst(12'h03F, 772, 3);
        repeat (10) @(posedge sys_clk_i);
        for (int c = 0; c < 6; c++) begin
            chk(32'(cnt[c + 2] - base[c]), 32'(expn[c]), "pulse count");
        end
        $display("test prescale done");
        apb(1'b1, IDX_TCTL, 32'h04);
        base[0] = cnt[6];
        i_src.level(6, 1'b1);
        repeat (10) @(posedge sys_clk_i);
        chk(32'(cnt[6] - base[0]), 0, "rising ignored");
        i_src.level(6, 1'b0);
        repeat (10) @(posedge sys_clk_i);
        chk(32'(cnt[6] - base[0]), 1, "falling locked");
        apb(1'b1, IDX_TCTL, 32'h00);
        $display("test polarity done");
        // slowest activity limit and undivided codes: only the 155 MHz code may flag an input
        apb(1'b1, IDX_FCFG0 + 8'd2, 32'h38);
        apb(1'b1, IDX_FCFG0 + 8'd3, 32'h33);
        repeat (450) @(posedge sys_clk_i);
        chk(unavail[2], 1, "155 on single ended");
        chk(unavail[3], 0, "19.44 on single ended");
        apb(1'b0, IDX_UNAV, 32'h0);
        chk(rd[2], 1, "status bit");
        base[0] = cnt[6];
        i_src.burst(12'h010, 8, 3);
        repeat (10) @(posedge sys_clk_i);
        chk(32'(cnt[6] - base[0]), 8, "neighbour path");
        $display("test faults done");
        summarize();
    end
    initial begin
        repeat (30000) @(posedge sys_clk_i);
        errors++;
        summarize();
    end
endmodule : testbench
